//--- rtl/lssc_sequencer.sv
// Lens stepper sequencer with its two configuration registers
`timescale 1ns/1ps
`default_nettype none
module lssc_sequencer #(
  parameter int AF_CYCLES   = lssc_pkg::AF_PULSE_CYCLES,
  parameter int HOME_CYCLES = lssc_pkg::HOME_PULSE_CYCLES
) (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       reset_n,
  // Register port from the serial bus slave
  input  wire logic       regWrite,
  input  wire logic [7:0] regAddr,
  input  wire logic [7:0] regWriteData,
  output var  logic [7:0] regReadData,
  // Motor and status
  output var  logic [3:0] coilDrive,
  output var  logic [7:0] stepPosition,
  output var  logic       sequenceBusyFlag
);
  import lssc_pkg::*;

  logic [7:0]     lensStepControl;
  logic [5:0]     lensSequenceConfig;
  lssc_state_type state;
  logic [7:0]     pulseLeft;
  logic [7:0]     holdLoad;
  logic [7:0]     stepLeft;
  logic [2:0]     phaseIdx;
  logic           homeRun;
  logic           halfStepRun;
  logic           counterRelease;
  logic           startReq;
  logic [7:0]     next_stepTotal;

  lssc_tick_if tickBus ();

  // Below four cycles the halved 1-2 phase period would leave the timer no count
  if (AF_CYCLES < 4 || HOME_CYCLES < 4) begin : g_bad_cycles
    $error("lssc_sequencer: tick periods below four cycles");
  end

  // Code 7 repeats the single pulse of code 0
  function automatic logic [7:0] holdPulses(input logic [2:0] code);
    case (code)
      3'h0:    holdPulses = 8'h01;
      3'h1:    holdPulses = 8'h02;
      3'h2:    holdPulses = 8'h04;
      3'h3:    holdPulses = 8'h05;
      3'h4:    holdPulses = 8'h08;
      3'h5:    holdPulses = 8'h10;
      3'h6:    holdPulses = 8'h20;
      default: holdPulses = 8'h01;
    endcase
  endfunction : holdPulses

  // Eight half-step patterns; 2-phase drive uses only the even entries
  function automatic logic [3:0] coilPattern(input logic [2:0] idx);
    case (idx)
      3'h0:    coilPattern = 4'hA;
      3'h1:    coilPattern = 4'h2;
      3'h2:    coilPattern = 4'h6;
      3'h3:    coilPattern = 4'h4;
      3'h4:    coilPattern = 4'h5;
      3'h5:    coilPattern = 4'h1;
      3'h6:    coilPattern = 4'h9;
      default: coilPattern = 4'h8;
    endcase
  endfunction : coilPattern

  assign counterRelease = lensStepControl[COUNTER_RELEASE_BIT];
  // A write of the step register with the release bit set launches a run
  assign startReq = regWrite && (regAddr == ADDR_STEP_CONTROL) && regWriteData[COUNTER_RELEASE_BIT];

  always_comb begin
    next_stepTotal = {2'h0, regWriteData[7:STEP_FIELD_LSB], 1'b0} + 8'h02;
    if (lensSequenceConfig[EXTEND_BIT] && next_stepTotal >= EXTEND_MIN_STEPS) begin
      next_stepTotal = next_stepTotal + EXTEND_STEPS;
    end
  end

  // Register writes; the busy bit is read-only
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      lensStepControl    <= STEP_CONTROL_RESET;
      lensSequenceConfig <= SEQUENCE_CONFIG_RESET;
    end else if (regWrite) begin
      if (regAddr == ADDR_STEP_CONTROL) begin
        lensStepControl <= regWriteData;
      end else if (regAddr == ADDR_SEQUENCE_CONFIG) begin
        lensSequenceConfig <= regWriteData[5:0];
      end
    end
  end

  // Read data is registered, one cycle behind the address
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      regReadData <= UNMAPPED_READ;
    end else if (regAddr == ADDR_STEP_CONTROL) begin
      regReadData <= lensStepControl;
    end else if (regAddr == ADDR_SEQUENCE_CONFIG) begin
      regReadData <= {sequenceBusyFlag, 1'b0, lensSequenceConfig};
    end else begin
      regReadData <= UNMAPPED_READ;
    end
  end

  // Sequence control; a new start is ignored while a run is in progress
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      state       <= SEQ_IDLE;
      pulseLeft   <= 8'h00;
      stepLeft    <= 8'h00;
      homeRun     <= 1'b0;
      halfStepRun <= 1'b0;
      holdLoad    <= 8'h00;
    // A restart write landing before an abort settles must not revive the old run
    end else if (!counterRelease && !(startReq && state == SEQ_IDLE)) begin
      state <= SEQ_IDLE;
    end else begin
      case (state)
        SEQ_IDLE: begin
          if (startReq) begin
            state       <= SEQ_HOLD_PRE;
            pulseLeft   <= holdPulses(lensSequenceConfig[HOLD_FIELD_LSB +: 3]);
            holdLoad    <= holdPulses(lensSequenceConfig[HOLD_FIELD_LSB +: 3]);
            stepLeft    <= next_stepTotal;
            homeRun     <= lensSequenceConfig[HOME_EN_BIT];
            halfStepRun <= lensSequenceConfig[EXCITE_BIT];
          end
        end
        SEQ_HOLD_PRE: begin
          if (tickBus.tick) begin
            if (pulseLeft == 8'h01) begin
              state <= SEQ_STEP;
            end else begin
              pulseLeft <= pulseLeft - 8'h01;
            end
          end
        end
        SEQ_STEP: begin
          if (tickBus.tick) begin
            stepLeft <= stepLeft - 8'h01;
            if (stepLeft == 8'h01) begin
              state     <= SEQ_HOLD_POST;
              // Latched at start so a config write during the run cannot skew the tail
              pulseLeft <= holdLoad;
            end
          end
        end
        SEQ_HOLD_POST: begin
          if (tickBus.tick) begin
            if (pulseLeft == 8'h01) begin
              state <= SEQ_IDLE;
            end else begin
              pulseLeft <= pulseLeft - 8'h01;
            end
          end
        end
        default: state <= SEQ_IDLE;
      endcase
    end
  end

  // Timer runs only while a sequence is active, so every run starts phase-aligned
  assign tickBus.run      = (state != SEQ_IDLE);
  assign tickBus.homeMode = homeRun;
  assign tickBus.halfStep = halfStepRun;

  // One shared timer paces hold and step ticks alike
  lssc_pulse_timer #(
    .AF_CYCLES   (AF_CYCLES),
    .HOME_CYCLES (HOME_CYCLES)
  ) u_timer (
    .sys_clk  (sys_clk),
    .reset_n  (reset_n),
    .tickPort (tickBus.timer)
  );

  // Busy follows the state one cycle late and drops by itself at the end
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      sequenceBusyFlag <= 1'b0;
    end else begin
      sequenceBusyFlag <= (state != SEQ_IDLE);
    end
  end

  // Step counter and coil phase, both cleared while the release bit is low
  always_ff @(posedge sys_clk) begin
    if (!reset_n || !counterRelease) begin
      stepPosition <= 8'h00;
      phaseIdx     <= 3'h0;
    end else if (state == SEQ_STEP && tickBus.tick) begin
      stepPosition <= stepPosition + 8'h01;
      phaseIdx     <= phaseIdx + (halfStepRun ? 3'h1 : 3'h2);
    end
  end

  // Pattern lags the phase by one cycle so the coil pins come straight from flops
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      coilDrive <= COIL_REST;
    end else begin
      coilDrive <= coilPattern(phaseIdx);
    end
  end
endmodule : lssc_sequencer
`default_nettype wire

//--- rtl/lssc_pkg.sv
// Shared constants and types of the lens stepper sequencer
package lssc_pkg;
  // Register offsets on the serial register map
  localparam logic [7:0] ADDR_STEP_CONTROL    = 8'h00;
  localparam logic [7:0] ADDR_SEQUENCE_CONFIG = 8'h01;
  // Reset values
  localparam logic [7:0] STEP_CONTROL_RESET    = 8'h00;
  localparam logic [5:0] SEQUENCE_CONFIG_RESET = 6'h00;
  localparam logic [7:0] UNMAPPED_READ         = 8'h00;
  // Field positions, step control register
  localparam int STEP_FIELD_LSB      = 3;
  localparam int COUNTER_RELEASE_BIT = 2;
  // Field positions, sequence config register
  localparam int HOLD_FIELD_LSB = 0;
  localparam int EXCITE_BIT     = 3;
  localparam int HOME_EN_BIT    = 4;
  localparam int EXTEND_BIT     = 5;
  localparam int BUSY_BIT       = 7;
  // Step arithmetic
  localparam logic [7:0] EXTEND_STEPS    = 8'h40;
  localparam logic [7:0] EXTEND_MIN_STEPS = 8'h40;
  // Coil pattern at rest: OUT1 high, OUT2 low, OUT3 high, OUT4 low
  localparam logic [3:0] COIL_REST = 4'hA;
  // Timing: one hold pulse per step period, halved for 1-2 phase drive
  localparam int SYS_CLK_MHZ        = 125;
  localparam int AF_PULSE_US        = 2000;
  localparam int HOME_PULSE_US      = 10000;
  localparam int AF_PULSE_CYCLES    = AF_PULSE_US * SYS_CLK_MHZ;
  localparam int HOME_PULSE_CYCLES  = HOME_PULSE_US * SYS_CLK_MHZ;
  localparam int TIMER_WIDTH        = 24;

  typedef enum logic [1:0] {
    SEQ_IDLE,
    SEQ_HOLD_PRE,
    SEQ_STEP,
    SEQ_HOLD_POST
  } lssc_state_type;
endpackage : lssc_pkg

//--- rtl/lssc_tick_if.sv
// Carrier between the sequencer and its pulse timer
`timescale 1ns/1ps
`default_nettype none
interface lssc_tick_if;
  logic run;
  logic homeMode;
  logic halfStep;
  logic tick;

  modport timer (input run, input homeMode, input halfStep, output tick);
  modport seq   (output run, output homeMode, output halfStep, input tick);
endinterface : lssc_tick_if
`default_nettype wire

//--- rtl/lssc_pulse_timer.sv
// Pulse period divider giving one-cycle step and hold ticks
`timescale 1ns/1ps
`default_nettype none
module lssc_pulse_timer #(
  parameter int AF_CYCLES   = lssc_pkg::AF_PULSE_CYCLES,
  parameter int HOME_CYCLES = lssc_pkg::HOME_PULSE_CYCLES
) (
  // Clock and reset
  input wire logic   sys_clk,
  input wire logic   reset_n,
  // Tick request and answer
  lssc_tick_if.timer tickPort
);
  import lssc_pkg::*;

  // Refused at elaboration: the counter must reach each period and its half
  if (AF_CYCLES < 4 || HOME_CYCLES < 4 ||
      AF_CYCLES >= (1 << TIMER_WIDTH) || HOME_CYCLES >= (1 << TIMER_WIDTH)) begin : g_bad_period
    $error("lssc_pulse_timer: period counts out of range");
  end

  localparam logic [TIMER_WIDTH-1:0] AF_PERIOD   = TIMER_WIDTH'(AF_CYCLES);
  localparam logic [TIMER_WIDTH-1:0] HOME_PERIOD = TIMER_WIDTH'(HOME_CYCLES);

  logic [TIMER_WIDTH-1:0] count;
  logic [TIMER_WIDTH-1:0] period;
  logic                   tickOut;

  // Home sequence runs at 100pps, focus at 500pps; 1-2 phase halves the period
  always_comb begin
    period = tickPort.homeMode ? HOME_PERIOD : AF_PERIOD;
    if (tickPort.halfStep) begin
      period = period >> 1;
    end
  end

  // Counter restarts whenever the sequencer goes idle so every run begins aligned
  always_ff @(posedge sys_clk) begin
    if (!reset_n || !tickPort.run) begin
      count   <= '0;
      tickOut <= 1'b0;
    end else if (count == period - 1'b1) begin
      count   <= '0;
      tickOut <= 1'b1;
    end else begin
      count   <= count + 1'b1;
      tickOut <= 1'b0;
    end
  end

  assign tickPort.tick = tickOut;
endmodule : lssc_pulse_timer
`default_nettype wire

//--- dv/lssc_asserts.sv
// Port checker of the lens stepper sequencer
`timescale 1ns/1ps
`default_nettype none
module lssc_asserts (
  // Clock and reset
  input wire logic       sys_clk,
  input wire logic       reset_n,
  // Register port
  input wire logic       regWrite,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWriteData,
  input wire logic [7:0] regReadData,
  // Motor and status
  input wire logic [3:0] coilDrive,
  input wire logic [7:0] stepPosition,
  input wire logic       sequenceBusyFlag
);
  import lssc_pkg::*;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  sequence s_clear; regWrite && regAddr == ADDR_STEP_CONTROL && !regWriteData[COUNTER_RELEASE_BIT]; endsequence
  sequence s_start; regWrite && regAddr == ADDR_STEP_CONTROL && regWriteData[COUNTER_RELEASE_BIT]; endsequence
  a_reset_rest: assert property ($rose(reset_n) |-> coilDrive == COIL_REST && stepPosition == 8'h00)
    else $error("outputs not at rest after reset");
  a_clear_holds: assert property (s_clear |=> ##2 stepPosition == 8'h00 && !sequenceBusyFlag)
    else $error("counter not held after clear");
  a_start_busy: assert property (s_start ##0 !sequenceBusyFlag |-> ##2 sequenceBusyFlag)
    else $error("busy did not rise after start");
  a_busy_cause: assert property ($rose(sequenceBusyFlag) |-> $past(regWrite && regAddr == 8'h00 && regWriteData[2], 2))
    else $error("busy rose without start");
  a_step_advance: assert property ($changed(stepPosition) |->
    stepPosition == 8'h00 || (stepPosition == $past(stepPosition) + 8'h01 && sequenceBusyFlag))
    else $error("step counter jumped");
  a_busy_readback: assert property ($past(regAddr) == 8'h01 |-> regReadData[7:6] == {$past(sequenceBusyFlag), 1'b0})
    else $error("busy bit readback wrong");
  a_idle_no_step: assert property (!sequenceBusyFlag |-> $stable(stepPosition) || stepPosition == 8'h00)
    else $error("step while idle");
  a_coil_valid: assert property (coilDrive inside {4'hA, 4'h2, 4'h6, 4'h4, 4'h5, 4'h1, 4'h9, 4'h8})
    else $error("illegal coil pattern");
  a_unmapped_zero: assert property ($past(regAddr) > 8'h01 |-> regReadData == UNMAPPED_READ)
    else $error("unmapped read not zero");
endmodule : lssc_asserts
bind lssc_sequencer lssc_asserts u_asserts (.*);
`default_nettype wire

//--- dv/lssc_host.sv
// Host model driving the register byte port
`timescale 1ns/1ps
`default_nettype none
module lssc_host (
  // Clock and read data
  input  wire logic       sys_clk,
  input  wire logic [7:0] regReadData,
  // Write side
  output var  logic       regWrite,
  output var  logic [7:0] regAddr,
  output var  logic [7:0] regWriteData
);
  initial begin
    regWrite = 1'b0;
    regAddr = 8'h00;
    regWriteData = 8'h00;
  end
  // Data is inverted after the strobe so a stale byte never looks valid
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    regWrite <= 1'b1;
    regAddr <= a;
    regWriteData <= d;
    @(posedge sys_clk);
    regWrite <= 1'b0;
    regWriteData <= ~d;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    repeat (2) @(posedge sys_clk);
    d = regReadData;
  endtask : rd
endmodule : lssc_host
`default_nettype wire

//--- dv/lssc_sequencer_tb.sv
// Self-checking bench of the lens stepper sequencer
`timescale 1ns/1ps
`default_nettype none
module lssc_sequencer_tb;
  import lssc_pkg::*;
  localparam int AF_CYCLES = 8;
  localparam int HOME_CYCLES = 40;
  logic       sys_clk = 1'b0;
  logic       reset_n = 1'b0;
  logic       regWrite, sequenceBusyFlag;
  logic [7:0] regAddr, regWriteData, regReadData, stepPosition, rdv, cfg;
  logic [3:0] coilDrive;
  logic [4:0] f;
  int         fails = 0, n_compared = 0, seed = 54600, len = 0, s;
  logic [7:0] expSteps[$];
  int         expLen[$];
  logic [3:0] expCoil[$];
  logic [3:0] coilSeq[8] = '{4'hA, 4'h2, 4'h6, 4'h4, 4'h5, 4'h1, 4'h9, 4'h8};
  int         holdN[8] = '{1, 2, 4, 5, 8, 16, 32, 1};
  logic [7:0] extCfg[5] = '{8'h20, 8'h28, 8'h20, 8'h38, 8'h10};
  lssc_sequencer #(.AF_CYCLES(AF_CYCLES), .HOME_CYCLES(HOME_CYCLES)) u_dut (.*);
  lssc_host u_host (.*);
  initial forever #4 sys_clk = ~sys_clk;
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic results();
    $display("fails=%0d n_compared=%0d", fails, n_compared);
    if (fails == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : results
  // Busy stands one cycle past the last tick of a run
  always @(posedge sys_clk) begin
    if (sequenceBusyFlag === 1'b1) len <= len + 1;
    else if (len > 0) begin
      chk(stepPosition, expSteps[0]);
      chk(coilDrive, expCoil[0]);
      if (expLen[0] >= 0) chk(16'(len), 16'(expLen[0] + 1));
      void'(expSteps.pop_front());
      void'(expCoil.pop_front());
      void'(expLen.pop_front());
      len <= 0;
    end
  end
  initial begin
    repeat (60000) @(posedge sys_clk);
    fails++;
    results();
  end
  initial begin
    repeat (12) @(posedge sys_clk);
    reset_n <= 1'b1;
    u_host.rd(8'h00, rdv);
    chk(rdv, STEP_CONTROL_RESET);
    u_host.rd(8'h01, rdv);
    chk(rdv, {2'b00, SEQUENCE_CONFIG_RESET});
    u_host.rd(8'h07, rdv);
    chk(rdv, UNMAPPED_READ);
    u_host.wr(8'h01, 8'hFF);
    u_host.rd(8'h01, rdv);
    chk(rdv, 8'h3F);
    u_host.wr(8'h00, 8'hA3);
    u_host.rd(8'h00, rdv);
    chk(rdv, 8'hA3);
    for (int i = 0; i < 13; i++) begin
      cfg = (i < 8) ? {3'b000, 2'(i), 3'(i)} : extCfg[i - 8];
      f = (i < 8) ? 5'($random(seed)) : ((i == 10) ? 5'h1E : 5'h1F);
      s = 2 * f + 2 + ((cfg[5] && f == 5'h1F) ? 64 : 0);
      u_host.wr(8'h01, cfg);
      u_host.wr(8'h00, 8'h00);
      u_host.wr(8'h00, {f, 3'b100});
      expSteps.push_back((i == 12) ? 8'h00 : 8'(s));
      expCoil.push_back((i == 12) ? COIL_REST : coilSeq[3'(s * (cfg[3] ? 1 : 2))]);
      expLen.push_back((i == 12) ? -1 : (2 * holdN[cfg[2:0]] + s) * ((cfg[4] ? HOME_CYCLES : AF_CYCLES) >> cfg[3]));
      u_host.rd(8'h01, rdv);
      chk(rdv, {2'b10, cfg[5:0]});
      if (i == 12) begin
        repeat (200) @(posedge sys_clk);
        u_host.wr(8'h00, 8'h00);
      end
      for (int k = 0; k < 9000 && expSteps.size() > 0; k++) @(posedge sys_clk);
      chk(16'(expSteps.size()), 16'h0000);
    end
    results();
  end
endmodule : lssc_sequencer_tb
`default_nettype wire
